/* shared/cbsd_map.svh */
// address map, field positions and timing counts of the coprocessor bus port
`ifndef CBSD_MAP_SVH
`define CBSD_MAP_SVH
`define CBSD_UPPER_HI 31
`define CBSD_UPPER_LO 25
`define CBSD_UPPER_W 7
`define CBSD_UPPER_MATCH 7'h60
`define CBSD_SPACE_BASE 32'hc0000000
`define CBSD_SPACE_LAST 32'hc1ffffff
`define CBSD_CONV_LAST 32'hc000ffff
`define CBSD_INSTR_HI 15
`define CBSD_INSTR_LO 2
`define CBSD_INSTR_W 14
`define CBSD_OP_W 17
`define CBSD_READ_WAIT 2'h1
`define CBSD_RESULT_INIT 32'h00000000
`endif

/* shared/cbsd_pkg.sv */
// types shared by both ends of the coprocessor bus port
`default_nettype none
package cbsd_pkg;
  typedef logic [16:0] cbsd_op_t;
  typedef enum logic [1:0] {CBSD_IDLE, CBSD_WAIT, CBSD_ACK} cbsd_state_e;
endpackage : cbsd_pkg
`default_nettype wire

/* shared/cbsd_if.sv */
// bus wires between host side logic and the coprocessor port
`default_nettype none
interface cbsd_if;
  logic [31:0] addr;
  logic [2:0] low_byte_enables_n;
  logic mem_io;
  logic write_read;
  logic address_strobe_n;
  logic bus_ready_n;
  logic [31:0] host_data_out;
  logic host_data_oe;
  logic [31:0] dev_data_out;
  logic dev_data_oe;
  logic coproc_ack_n_out;
  logic coproc_ack_oe;
  logic chipset_ack_n_out;
  logic chipset_ack_oe;
  logic coproc_select_n;
  logic presence_n;
  logic coproc_interrupt;
  logic three_cycle_strap_n;
  logic [31:0] host_data_bus;
  logic coproc_ack_n;
  assign host_data_bus = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 32'h0);
  assign coproc_ack_n = coproc_ack_oe ? coproc_ack_n_out : 1'b1;
  modport device (
    input addr, low_byte_enables_n, mem_io, write_read, address_strobe_n, bus_ready_n,
    input host_data_bus, three_cycle_strap_n,
    output dev_data_out, dev_data_oe, coproc_ack_n_out, coproc_ack_oe,
    output chipset_ack_n_out, chipset_ack_oe, coproc_select_n, presence_n, coproc_interrupt
  );
  modport host (
    output addr, low_byte_enables_n, mem_io, write_read, address_strobe_n, bus_ready_n,
    output host_data_out, host_data_oe, three_cycle_strap_n,
    input host_data_bus, coproc_ack_n, coproc_select_n, presence_n, coproc_interrupt
  );
endinterface : cbsd_if
`default_nettype wire

/* core/cbsd_device.sv */
// coprocessor end: select decode, instruction capture, read drive and acknowledge
// How it works
// - select from upper seven bits and memory qualifier
// - respond only inside c0000000 to c1ffffff
// - instruction is address 15..2 plus byte enables
// - write executes instruction, read drives data bus
// - host keeps others out of decoded range
// - system acks itself when coprocessor absent
// - presence driven low; high means absent
// - system routes interrupt to controller
// - sample and launch on rising clock edge
// - capture data only in write cycles
// - strap low: ack floats when idle, chipset ack copies it
// - system ors ack into bus ready
// - select follows address combinationally
// - reset asynchronous, active high
`include "cbsd_map.svh"
`default_nettype none
module cbsd_device (
  input wire logic mclk,
  input wire logic reset,
  cbsd_if.device bus,
  output logic exec_valid,
  output logic [16:0] exec_op,
  output logic [31:0] exec_data,
  output logic read_req,
  output logic [16:0] read_op,
  input wire logic [31:0] read_result,
  input wire logic interrupt_req
);
  // decode wires
  wire upper_match;
  wire sel_hit;
  wire cycle_start;
  wire wr_start;
  wire rd_start;
  wire strap_low;
  wire st_idle;
  wire st_wait;
  wire st_ack;
  wire ack_now;
  wire cycle_busy;
  wire in_read;
  wire host_ready;
  wire write_take;
  wire wdata_load;
  wire rdata_load;
  cbsd_pkg::cbsd_op_t op_now;

  // registered state
  cbsd_pkg::cbsd_state_e state_ff, nxt_state;
  logic is_write_ff, nxt_is_write;
  cbsd_pkg::cbsd_op_t op_ff, nxt_op;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic exec_valid_ff;
  logic nxt_exec_valid;
  logic ack_seen_ff;
  logic nxt_ack_seen;
  logic irq_ff;

  // only the top seven address bits and the memory qualifier select the port
  assign upper_match = bus.addr[`CBSD_UPPER_HI:`CBSD_UPPER_LO] == `CBSD_UPPER_MATCH;
  assign sel_hit = bus.mem_io && upper_match;
  assign bus.coproc_select_n = ~sel_hit;
  assign op_now = {bus.addr[`CBSD_INSTR_HI:`CBSD_INSTR_LO], bus.low_byte_enables_n};

  // state decode
  assign st_idle = (state_ff == cbsd_pkg::CBSD_IDLE);
  assign st_wait = (state_ff == cbsd_pkg::CBSD_WAIT);
  assign st_ack = (state_ff == cbsd_pkg::CBSD_ACK);
  assign cycle_busy = ~st_idle;
  assign ack_now = st_ack;
  assign host_ready = ~bus.bus_ready_n;

  // a cycle starts on a strobe that hits the space while idle
  assign cycle_start = st_idle && ~bus.address_strobe_n && sel_hit;
  assign wr_start = cycle_start && bus.write_read;
  assign rd_start = cycle_start && ~bus.write_read;
  assign in_read = ~is_write_ff && cycle_busy;
  assign write_take = ack_now && is_write_ff && host_ready;

  // write data is taken in the first acknowledge cycle only, so data that
  // changes while the host delays ready is not used
  assign wdata_load = ack_now && is_write_ff && ~ack_seen_ff;
  assign rdata_load = st_wait && ~is_write_ff;
  assign nxt_wdata = wdata_load ? bus.host_data_bus : wdata_ff;
  assign nxt_rdata = rdata_load ? read_result : rdata_ff;
  assign nxt_exec_valid = write_take;
  assign nxt_ack_seen = ack_now;

  // strap and fixed pins
  assign strap_low = ~bus.three_cycle_strap_n;
  assign bus.presence_n = 1'b0;
  assign bus.coproc_interrupt = irq_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_is_write = is_write_ff;
    nxt_op = op_ff;
    case (state_ff)
      cbsd_pkg::CBSD_IDLE:
      begin
        if (cycle_start)
        begin
          nxt_op = op_now;
          nxt_is_write = bus.write_read;
        end
        if (wr_start)
          nxt_state = cbsd_pkg::CBSD_ACK;
        else if (rd_start)
          nxt_state = cbsd_pkg::CBSD_WAIT; // one wait state before read data
      end
      cbsd_pkg::CBSD_WAIT:
      begin
        nxt_state = cbsd_pkg::CBSD_ACK;
      end
      cbsd_pkg::CBSD_ACK:
      begin
        if (host_ready)
          nxt_state = cbsd_pkg::CBSD_IDLE;
      end
      default:
      begin
        nxt_state = cbsd_pkg::CBSD_IDLE;
      end
    endcase
  end

  // cycle state
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= cbsd_pkg::CBSD_IDLE;
      is_write_ff <= 1'b0;
      op_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      is_write_ff <= nxt_is_write;
      op_ff <= nxt_op;
    end
  end

  // data registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wdata_ff <= `CBSD_RESULT_INIT;
      rdata_ff <= `CBSD_RESULT_INIT;
    end
    else
    begin
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  // execute strobe and acknowledge history
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      exec_valid_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end
    else
    begin
      exec_valid_ff <= nxt_exec_valid;
      ack_seen_ff <= nxt_ack_seen;
    end
  end

  // interrupt request is registered so the pin changes only after a rising edge
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq_ff <= 1'b0;
    else
      irq_ff <= interrupt_req;
  end

  // core side
  assign exec_valid = exec_valid_ff;
  assign exec_op = op_ff;
  assign exec_data = wdata_ff;
  assign read_req = st_wait;
  assign read_op = op_ff;

  // read data is driven from the clock edge that samples the strobe to the end of the cycle,
  // valid only once the acknowledge is low
  assign bus.dev_data_out = rdata_ff;
  assign bus.dev_data_oe = in_read;

  // with the strap high the acknowledge is always driven; with it low the
  // acknowledge floats when idle and the chipset acknowledge copies it
  assign bus.coproc_ack_n_out = ~ack_now;
  assign bus.coproc_ack_oe = strap_low ? cycle_busy : 1'b1;
  assign bus.chipset_ack_n_out = ~ack_now;
  assign bus.chipset_ack_oe = strap_low && cycle_busy;
endmodule : cbsd_device
`default_nettype wire

/* core/cbsd_host.sv */
// host end: bus cycles to the coprocessor space and ready merging
`include "cbsd_map.svh"
`default_nettype none
module cbsd_host (
  input wire logic mclk,
  input wire logic reset,
  cbsd_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [2:0] req_be_n,
  input wire logic [31:0] req_wdata,
  input wire logic strap_n,
  output logic req_ready,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic absent,
  output logic irq13
);
  cbsd_pkg::cbsd_state_e state_ff, nxt_state;
  logic [31:0] addr_ff;
  logic [2:0] be_ff;
  logic wr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic resp_ff;
  wire in_space = addr_ff[`CBSD_UPPER_HI:`CBSD_UPPER_LO] == `CBSD_UPPER_MATCH;
  // cycles outside the space belong to other memory and end at once; a missing
  // coprocessor is acked here so the host never hangs
  wire self_ack = (state_ff != cbsd_pkg::CBSD_IDLE) && (!in_space || bus.presence_n);
  wire ready_n = bus.coproc_ack_n & ~self_ack;
  wire done = (state_ff != cbsd_pkg::CBSD_IDLE) && ~ready_n;

  assign bus.addr = addr_ff;
  assign bus.low_byte_enables_n = be_ff;
  assign bus.mem_io = 1'b1;
  assign bus.write_read = wr_ff;
  assign bus.address_strobe_n = ~(state_ff == cbsd_pkg::CBSD_WAIT);
  assign bus.bus_ready_n = ready_n;
  assign bus.host_data_out = wdata_ff;
  assign bus.host_data_oe = wr_ff && (state_ff != cbsd_pkg::CBSD_IDLE);
  assign bus.three_cycle_strap_n = strap_n;
  assign req_ready = (state_ff == cbsd_pkg::CBSD_IDLE);
  assign resp_valid = resp_ff;
  assign resp_rdata = rdata_ff;
  assign absent = bus.presence_n;
  assign irq13 = bus.coproc_interrupt;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cbsd_pkg::CBSD_IDLE: if (req_valid) nxt_state = cbsd_pkg::CBSD_WAIT;
      cbsd_pkg::CBSD_WAIT: nxt_state = done ? cbsd_pkg::CBSD_IDLE : cbsd_pkg::CBSD_ACK;
      cbsd_pkg::CBSD_ACK: if (done) nxt_state = cbsd_pkg::CBSD_IDLE;
      default: nxt_state = cbsd_pkg::CBSD_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= cbsd_pkg::CBSD_IDLE;
      addr_ff <= '0;
      be_ff <= 3'h7;
      wr_ff <= 1'b0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      resp_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      resp_ff <= done;
      if (state_ff == cbsd_pkg::CBSD_IDLE && req_valid)
      begin
        addr_ff <= req_addr;
        be_ff <= req_be_n;
        wr_ff <= req_write;
        wdata_ff <= req_wdata;
      end
      if (done && !wr_ff)
        rdata_ff <= bus.host_data_bus;
    end
  end
endmodule : cbsd_host
`default_nettype wire

/* test/cbsd_properties.sv */
// concurrent checks on the wires between host end and coprocessor end
`default_nettype none
module cbsd_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] addr,
  input wire logic mem_io,
  input wire logic write_read,
  input wire logic address_strobe_n,
  input wire logic coproc_select_n,
  input wire logic coproc_ack_n,
  input wire logic dev_data_oe,
  input wire logic presence_n,
  input wire logic three_cycle_strap_n,
  input wire logic chipset_ack_oe,
  input wire logic chipset_ack_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire logic take = !address_strobe_n && !coproc_select_n;
  sel_decode_a: assert property (coproc_select_n == !(mem_io && addr[31:25] == 7'h60))
    else $error("select decode wrong");
  sel_range_a: assert property (!coproc_select_n |-> addr >= 32'hc0000000 && addr <= 32'hc1ffffff)
    else $error("select outside space");
  wr_ack_a: assert property (take && write_read |=> !coproc_ack_n)
    else $error("write not acked next cycle");
  rd_ack_a: assert property (take && !write_read |=> coproc_ack_n ##1 !coproc_ack_n)
    else $error("read ack timing wrong");
  rd_drive_a: assert property (take && !write_read |=> dev_data_oe [*2])
    else $error("read data not driven");
  wr_quiet_a: assert property (take && write_read |=> !dev_data_oe)
    else $error("data driven in write");
  presence_n_low_a: assert property (presence_n == 1'b0)
    else $error("presence not shown");
  strap_hi_a: assert property (three_cycle_strap_n && $stable(three_cycle_strap_n) |-> !chipset_ack_oe)
    else $error("chipset ack used with strap high");
  strap_lo_a: assert property (!three_cycle_strap_n && !coproc_ack_n |-> chipset_ack_oe && !chipset_ack_n_out)
    else $error("chipset ack missing with strap low");
  wr_c: cover property (take && write_read);
  rd_c: cover property (take && !write_read);
  strap_c: cover property (!three_cycle_strap_n && !coproc_ack_n);
  miss_c: cover property (!address_strobe_n && coproc_select_n);
endmodule : cbsd_properties
`default_nettype wire

/* test/coproc_bus_select_decode_tb.sv */
// randomised bench for both ends of the coprocessor bus port
`default_nettype none
module coproc_bus_select_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, strap_n = 1'b1, interrupt_req = 1'b0;
  logic [31:0] req_addr = 32'hc0000000, req_wdata = 32'h0, read_result = 32'h0;
  logic [2:0] req_be_n = 3'h0;
  logic req_ready, resp_valid, absent, irq13, exec_valid, read_req;
  logic [31:0] resp_rdata, exec_data;
  cbsd_pkg::cbsd_op_t exec_op, read_op;
  int fails = 0, cmp_count = 0;
  cbsd_if bus_if ();
  always #4 mclk = ~mclk;
  cbsd_host u_cbsd_host (.mclk(mclk), .reset(reset), .bus(bus_if), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_be_n(req_be_n), .req_wdata(req_wdata),
    .strap_n(strap_n), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .absent(absent), .irq13(irq13));
  cbsd_device u_cbsd_device (.mclk(mclk), .reset(reset), .bus(bus_if),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_data(exec_data), .read_req(read_req),
    .read_op(read_op), .read_result(read_result), .interrupt_req(interrupt_req));
  cbsd_properties u_cbsd_properties (.mclk(mclk), .reset(reset), .addr(bus_if.addr),
    .mem_io(bus_if.mem_io), .write_read(bus_if.write_read),
    .address_strobe_n(bus_if.address_strobe_n), .coproc_select_n(bus_if.coproc_select_n),
    .coproc_ack_n(bus_if.coproc_ack_n), .dev_data_oe(bus_if.dev_data_oe),
    .presence_n(bus_if.presence_n), .three_cycle_strap_n(bus_if.three_cycle_strap_n),
    .chipset_ack_oe(bus_if.chipset_ack_oe), .chipset_ack_n_out(bus_if.chipset_ack_n_out));
  function automatic logic [16:0] op_of(input logic [31:0] a, input logic [2:0] b);
    return {a[15:2], b};
  endfunction : op_of
  function automatic logic [31:0] res_of(input logic [16:0] op);
    return {op[14:0], op} ^ 32'h5a5a0000;
  endfunction : res_of
  // coprocessor result source, answers whatever instruction is being read
  always @(negedge mclk) read_result <= res_of(read_op);
  task automatic chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("ERROR %0t: unexpected value", $time);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] b,
    input logic [31:0] d);
    int n;
    logic seen;
    @(negedge mclk);
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(negedge mclk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_be_n = b;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
    seen = 1'b0;
    for (n = 0; !seen && n < 20; n++)
    begin
      @(posedge mclk);
      #1;
      seen = wr ? exec_valid === 1'b1 : resp_valid === 1'b1;
    end
    chk(seen);
    if (wr)
      chk(exec_op === op_of(a, b) && exec_data === d);
    else
    begin
      chk(resp_rdata === res_of(op_of(a, b)));
      chk(read_op === op_of(a, b));
    end
  endtask : xfer
  // cycle outside the coprocessor space: ended by system logic, ignored by the port
  task automatic miss(input logic wr, input logic [31:0] a);
    int n;
    logic seen;
    logic hit;
    @(negedge mclk);
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(negedge mclk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = $urandom;
    @(negedge mclk);
    req_valid = 1'b0;
    seen = 1'b0;
    hit = 1'b0;
    for (n = 0; !seen && n < 20; n++)
    begin
      @(posedge mclk);
      #1;
      seen = resp_valid === 1'b1;
      hit = hit | exec_valid !== 1'b0 | read_req !== 1'b0 | bus_if.coproc_select_n !== 1'b1;
    end
    chk(seen);
    chk(!hit);
    if (!wr)
      chk(resp_rdata === 32'h0);
  endtask : miss
  initial
  begin
    logic [31:0] a;
    logic [31:0] d;
    logic [2:0] b;
    logic [31:0] m;
    void'($urandom(32'h535e2d30));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      @(negedge mclk);
      strap_n = s[0];
      for (int i = 0; i < 24; i++)
      begin
        a = i == 0 ? 32'hc0000000 : i == 1 ? 32'hc000ffff : i == 2 ? 32'hc1ffffff :
          {7'h60, 25'($urandom)};
        b = 3'($urandom);
        d = $urandom;
        xfer(1'b1, a, b, d);
        xfer(1'b0, a, b, 32'h0);
        m = i == 0 ? 32'hc2000000 : i == 1 ? 32'hbfffffff : {7'($urandom), 25'($urandom)};
        if (m[31:25] == 7'h60)
          m[31:25] = 7'h61;
        miss(i[0], m);
        @(negedge mclk);
        interrupt_req = 1'($urandom);
        repeat (3) @(negedge mclk);
        chk(irq13 === interrupt_req);
        chk(absent === 1'b0);
      end
    end
    tally_and_finish();
  end
  initial
  begin
    #100us;
    fails++;
    tally_and_finish();
  end
endmodule : coproc_bus_select_decode_tb
`default_nettype wire
